// file: verilog/fnc_regs.svh
// register offsets, field positions, reset values and timing for the fieldbus node block
// assumes a 32-bit AXI4-Lite register bus and a 100 MHz core clock
`ifndef FNC_REGS_SVH
`define FNC_REGS_SVH

`define FNC_OFF_CONFIG   8'h00
`define FNC_OFF_STATUS   8'h04
`define FNC_OFF_MASK     8'h08
`define FNC_OFF_STATE    8'h0C

`define FNC_CFG_NODE_LSB  0
`define FNC_CFG_RATE_LSB  8
`define FNC_CFG_FMT_LSB   12
`define FNC_CFG_ORDER_LSB 16
`define FNC_CFG_SLOTS_BIT 20

`define FNC_ST_PRESENCE  0
`define FNC_ST_REJECT    1
`define FNC_ST_NET_ERR   2
`define FNC_ST_MOD_ERR   3

`define FNC_NODE_MAX     6'h3F
`define FNC_NODE_RST     6'h3F
`define FNC_RATE_RST     2'h0
`define FNC_FMT_RST      2'h1
`define FNC_ORDER_RST    2'h2
`define FNC_SLOTS_RST    1'b0
`define FNC_MASK_RST     4'h0

`define FNC_RATE_125K    2'h0
`define FNC_RATE_250K    2'h1
`define FNC_RATE_500K    2'h2
`define FNC_FMT_DIV      2'h0
`define FNC_FMT_INT      2'h1
`define FNC_FMT_FLOAT    2'h2

`define FNC_CLK_HZ       100000000
`define FNC_BPS_125K     125000
`define FNC_BPS_250K     250000
`define FNC_BPS_500K     500000
`define FNC_FLASH_HALF_MS 500

`define FNC_RESP_OKAY    2'h0
`define FNC_RESP_SLVERR  2'h2

`endif

// file: verilog/fnc_pkg.sv
// types shared by the fieldbus node configuration and status block
// constants live in fnc_regs.svh
package fnc_pkg;

  typedef enum logic [2:0] {
    LAMP_OFF,
    LAMP_GREEN,
    LAMP_RED,
    LAMP_FLASH_GREEN,
    LAMP_FLASH_RED,
    LAMP_FLASH_ORANGE
  } fnc_lamp_t;

  typedef enum logic [2:0] {
    REG_CONFIG,
    REG_STATUS,
    REG_MASK,
    REG_STATE,
    REG_NONE
  } fnc_reg_t;

  typedef struct packed {
    logic [10:0] sync1;
    logic [10:0] sync2;
    logic [10:0] prev;
    logic [5:0]  node;
    logic [1:0]  rate;
    logic [1:0]  fmt;
    logic [1:0]  order;
    logic        two_slots;
    logic [3:0]  status;
    logic [3:0]  mask;
    logic        irq;
    logic        aw_held;
    logic [31:0] aw_addr;
    logic        w_held;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [25:0] flash_cnt;
    logic        flash;
    logic [9:0]  bit_cnt;
    logic        bit_tick;
    logic [1:0]  mod_lamp;
    logic [1:0]  net_lamp;
  } fnc_state_t;

endpackage

// file: verilog/fnc_node.sv
// fieldbus node configuration registers, board detection and status lamp encoding
// assumes option-board and network status pins are asynchronous to aclk
`timescale 1ns/1ns
`include "fnc_regs.svh"

module fnc_node
  import fnc_pkg::*;
#(
  parameter int unsigned FLASH_HALF_CYC = `FNC_FLASH_HALF_MS * (`FNC_CLK_HZ / 1000)
)
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        board_present,
  input  wire logic        board_power,
  input  wire logic        board_fault,
  input  wire logic        board_unrecov,
  input  wire logic        board_recov,
  input  wire logic        board_selftest,
  input  wire logic        net_power,
  input  wire logic        net_attached,
  input  wire logic        net_polled,
  input  wire logic        net_link_err,
  input  wire logic        net_timeout,
  output logic [1:0]       link_rate,
  output logic             link_bit_tick,
  output logic             module_health_lamp_green,
  output logic             module_health_lamp_red,
  output logic             network_health_lamp_green,
  output logic             network_health_lamp_red,
  output logic             irq
);

  fnc_state_t s;
  fnc_state_t n;

  logic        present;
  logic        brd_pwr;
  logic        brd_fault;
  logic        brd_unrec;
  logic        brd_recov;
  logic        brd_test;
  logic        nw_pwr;
  logic        nw_att;
  logic        nw_poll;
  logic        nw_link;
  logic        nw_to;
  logic        wr_go;
  logic        rd_go;
  logic        cfg_reject;
  logic        cfg_write;
  fnc_reg_t    wr_sel;
  fnc_reg_t    rd_sel;
  logic [31:0] merged;
  logic [3:0]  events;
  fnc_lamp_t   mod_mode;
  fnc_lamp_t   net_mode;

  function automatic fnc_reg_t decode(input logic [31:0] addr);
    fnc_reg_t r;
    r = REG_NONE;
    if (addr[31:8] == 24'h00_0000)
    begin
      case (addr[7:0])
        `FNC_OFF_CONFIG: r = REG_CONFIG;
        `FNC_OFF_STATUS: r = REG_STATUS;
        `FNC_OFF_MASK:   r = REG_MASK;
        `FNC_OFF_STATE:  r = REG_STATE;
        default:         r = REG_NONE;
      endcase
    end
    return r;
  endfunction

  function automatic logic [1:0] lamp_bits(input fnc_lamp_t m, input logic fl);
    logic [1:0] b;
    b = 2'h0;
    case (m)
      LAMP_OFF:          b = 2'h0;
      LAMP_GREEN:        b = 2'h1;
      LAMP_RED:          b = 2'h2;
      LAMP_FLASH_GREEN:  b = fl ? 2'h1 : 2'h0;
      LAMP_FLASH_RED:    b = fl ? 2'h2 : 2'h0;
      LAMP_FLASH_ORANGE: b = fl ? 2'h3 : 2'h0;
      default:           b = 2'h0;
    endcase
    return b;
  endfunction

  function automatic logic [9:0] bit_cycles(input logic [1:0] rate);
    logic [9:0] c;
    c = 10'(`FNC_CLK_HZ / `FNC_BPS_125K);
    case (rate)
      `FNC_RATE_250K: c = 10'(`FNC_CLK_HZ / `FNC_BPS_250K);
      `FNC_RATE_500K: c = 10'(`FNC_CLK_HZ / `FNC_BPS_500K);
      default:        c = 10'(`FNC_CLK_HZ / `FNC_BPS_125K);
    endcase
    return c;
  endfunction

  function automatic logic [31:0] cfg_word(input fnc_state_t t);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`FNC_CFG_NODE_LSB +: 6]  = t.node;
    w[`FNC_CFG_RATE_LSB +: 2]  = t.rate;
    w[`FNC_CFG_FMT_LSB +: 2]   = t.fmt;
    w[`FNC_CFG_ORDER_LSB +: 2] = t.order;
    w[`FNC_CFG_SLOTS_BIT]      = t.two_slots;
    return w;
  endfunction

  assign present   = s.sync2[0];
  assign brd_pwr   = s.sync2[1];
  assign brd_fault = s.sync2[2];
  assign brd_unrec = s.sync2[3];
  assign brd_recov = s.sync2[4];
  assign brd_test  = s.sync2[5];
  assign nw_pwr    = s.sync2[6];
  assign nw_att    = s.sync2[7];
  assign nw_poll   = s.sync2[8];
  assign nw_link   = s.sync2[9];
  assign nw_to     = s.sync2[10];

  assign s_axi_awready = !s.aw_held && !s.bvalid;
  assign s_axi_wready  = !s.w_held && !s.bvalid;
  assign s_axi_arready = !s.rvalid;
  assign wr_go  = s.aw_held && s.w_held && !s.bvalid;
  assign rd_go  = s_axi_arvalid && s_axi_arready;
  assign wr_sel = decode(s.aw_addr);
  assign rd_sel = decode(s_axi_araddr);

  always_comb
  begin
    merged = cfg_word(s);
    for (int i = 0; i < 4; i++)
    begin
      if (s.wstrb[i])
      begin
        merged[i*8 +: 8] = s.wdata[i*8 +: 8];
      end
    end
  end

  assign cfg_write  = wr_go && (wr_sel == REG_CONFIG) && present;
  assign cfg_reject = cfg_write && ((merged[`FNC_CFG_NODE_LSB +: 8] > 8'(`FNC_NODE_MAX))
                      || (merged[`FNC_CFG_RATE_LSB +: 2] == 2'h3)
                      || (merged[`FNC_CFG_FMT_LSB +: 2] == 2'h3));

  always_comb
  begin
    mod_mode = LAMP_GREEN;
    if (!brd_pwr)
      mod_mode = LAMP_OFF;
    else if (brd_unrec)
      mod_mode = LAMP_RED;
    else if (brd_test)
      mod_mode = LAMP_FLASH_ORANGE;
    else if (brd_recov)
      mod_mode = LAMP_FLASH_RED;
    else if (brd_fault)
      mod_mode = LAMP_FLASH_GREEN;
    net_mode = LAMP_OFF;
    if (!nw_pwr)
      net_mode = LAMP_OFF;
    else if (nw_link)
      net_mode = LAMP_RED;
    else if (nw_to)
      net_mode = LAMP_FLASH_RED;
    else if (nw_poll)
      net_mode = LAMP_GREEN;
    else if (nw_att)
      net_mode = LAMP_FLASH_GREEN;
  end

  assign events = {(brd_unrec | brd_recov) & ~(s.prev[3] | s.prev[4]),
                   (nw_link | nw_to) & ~(s.prev[9] | s.prev[10]),
                   cfg_reject,
                   present ^ s.prev[0]};

  always_comb
  begin
    n = s;
    n.sync1 = {net_timeout, net_link_err, net_polled, net_attached, net_power,
               board_selftest, board_recov, board_unrecov, board_fault, board_power,
               board_present};
    n.sync2 = s.sync1;
    n.prev  = s.sync2;
    // write channel: address and data taken in either order
    if (s_axi_awvalid && s_axi_awready)
    begin
      n.aw_held = 1'b1;
      n.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      n.w_held = 1'b1;
      n.wdata  = s_axi_wdata;
      n.wstrb  = s_axi_wstrb;
    end
    if (wr_go)
    begin
      n.aw_held = 1'b0;
      n.w_held  = 1'b0;
      n.bvalid  = 1'b1;
      n.bresp   = (wr_sel == REG_NONE) ? `FNC_RESP_SLVERR : `FNC_RESP_OKAY;
      if (cfg_write && !cfg_reject)
      begin
        n.node  = merged[`FNC_CFG_NODE_LSB +: 6];
        n.rate  = merged[`FNC_CFG_RATE_LSB +: 2];
        n.fmt   = merged[`FNC_CFG_FMT_LSB +: 2];
        n.order = merged[`FNC_CFG_ORDER_LSB +: 2];
        n.two_slots = merged[`FNC_CFG_SLOTS_BIT] &&
                      (merged[`FNC_CFG_FMT_LSB +: 2] != `FNC_FMT_FLOAT);
      end
      if (wr_sel == REG_MASK && s.wstrb[0])
      begin
        n.mask = s.wdata[3:0];
      end
    end
    if (s.bvalid && s_axi_bready)
    begin
      n.bvalid = 1'b0;
    end
    // read channel; status clears on read, new events still land
    if (s.rvalid && s_axi_rready)
    begin
      n.rvalid = 1'b0;
    end
    if (rd_go)
    begin
      n.rvalid = 1'b1;
      n.rresp  = `FNC_RESP_OKAY;
      n.rdata  = 32'h0000_0000;
      case (rd_sel)
        REG_CONFIG: n.rdata = present ? cfg_word(s) : 32'h0000_0000;
        REG_STATUS: n.rdata = {28'h000_0000, s.status};
        REG_MASK:   n.rdata = {28'h000_0000, s.mask};
        REG_STATE:  n.rdata = {16'h0000, s.net_lamp, s.mod_lamp, 1'b0, s.sync2};
        default:    n.rresp = `FNC_RESP_SLVERR;
      endcase
    end
    n.status = ((rd_go && rd_sel == REG_STATUS) ? 4'h0 : s.status) | events;
    n.irq    = |(n.status & n.mask);
    // lamp flash prescaler
    if (s.flash_cnt == 26'(FLASH_HALF_CYC - 1))
    begin
      n.flash_cnt = 26'h000_0000;
      n.flash     = !s.flash;
    end
    else
    begin
      n.flash_cnt = s.flash_cnt + 26'h000_0001;
    end
    // link bit timing at the selected rate
    n.bit_tick = 1'b0;
    if (s.bit_cnt >= bit_cycles(s.rate) - 10'h001)
    begin
      n.bit_cnt  = 10'h000;
      n.bit_tick = 1'b1;
    end
    else
    begin
      n.bit_cnt = s.bit_cnt + 10'h001;
    end
    n.mod_lamp = lamp_bits(mod_mode, s.flash);
    n.net_lamp = lamp_bits(net_mode, s.flash);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s           <= '0;
      s.node      <= `FNC_NODE_RST;
      s.rate      <= `FNC_RATE_RST;
      s.fmt       <= `FNC_FMT_RST;
      s.order     <= `FNC_ORDER_RST;
      s.two_slots <= `FNC_SLOTS_RST;
      s.mask      <= `FNC_MASK_RST;
    end
    else if (ce)
    begin
      s <= n;
    end
  end

  assign s_axi_bvalid              = s.bvalid;
  assign s_axi_bresp               = s.bresp;
  assign s_axi_rvalid              = s.rvalid;
  assign s_axi_rdata               = s.rdata;
  assign s_axi_rresp               = s.rresp;
  assign link_rate                 = s.rate;
  assign link_bit_tick             = s.bit_tick;
  assign module_health_lamp_green  = s.mod_lamp[0];
  assign module_health_lamp_red    = s.mod_lamp[1];
  assign network_health_lamp_green = s.net_lamp[0];
  assign network_health_lamp_red   = s.net_lamp[1];
  assign irq                       = s.irq;

  a_hidden_cfg: assert property (@(posedge aclk) disable iff (!aresetn || !ce)
    (wr_go && wr_sel == REG_CONFIG && !present) |=>
      $stable({s.node, s.rate, s.fmt, s.order, s.two_slots}))
    else $error("config changed while board absent");

  a_reject_keep: assert property (@(posedge aclk) disable iff (!aresetn || !ce)
    cfg_reject |=> ($stable(s.node) && s.status[`FNC_ST_REJECT]))
    else $error("refused write altered node or missed flag");

  a_rate_legal: assert property (@(posedge aclk) disable iff (!aresetn)
    (s.rate != 2'h3) && (s.fmt != 2'h3))
    else $error("illegal rate or format stored");

  a_slot_float: assert property (@(posedge aclk) disable iff (!aresetn)
    (s.fmt == `FNC_FMT_FLOAT) |-> !s.two_slots)
    else $error("two slots in float format");

  a_mod_dark: assert property (@(posedge aclk) disable iff (!aresetn || !ce)
    !brd_pwr |=> (s.mod_lamp == 2'h0))
    else $error("module lamp lit without board power");

  a_mod_unrec: assert property (@(posedge aclk) disable iff (!aresetn || !ce)
    (brd_pwr && brd_unrec) |=> (s.mod_lamp == 2'h2))
    else $error("module lamp not solid red");

  a_net_link: assert property (@(posedge aclk) disable iff (!aresetn || !ce)
    (nw_pwr && nw_link) |=> (s.net_lamp == 2'h2))
    else $error("network lamp not solid red on link error");

  a_net_green: assert property (@(posedge aclk) disable iff (!aresetn || !ce)
    (nw_pwr && !nw_link && !nw_to && nw_poll) |=> (s.net_lamp == 2'h1))
    else $error("network lamp not green while polled");

  a_flash_edge: assert property (@(posedge aclk) disable iff (!aresetn)
    $changed(s.flash) |-> (s.flash_cnt == 26'h000_0000))
    else $error("flash toggled off prescaler wrap");

endmodule

// file: verification/fnc_scanner_model.sv
// network scanner stand-in: drives the node's network status pins
// assumes tb picks a mode and pulses scan_rst to clear a bus-off
`timescale 1ns/1ns

module fnc_scanner_model
(
  input  wire logic       aclk,
  input  wire logic [2:0] mode,
  input  wire logic       scan_rst,
  output logic            net_power,
  output logic            net_attached,
  output logic            net_polled,
  output logic            net_link_err,
  output logic            net_timeout
);
  logic bus_off;

  // mode 0 unpowered, 1 listed nowhere, 2 polling, 3 cable fault, 4 timeout
  // the tb sets the single node's address over the register bus; the model drives no address
  assign net_power    = (mode != 3'h0);
  assign net_attached = (mode != 3'h0);
  assign net_polled   = (mode == 3'h2);
  assign net_timeout  = (mode == 3'h4);
  assign net_link_err = bus_off;

  // bus-off stays until the scanner itself is reset
  always_ff @(posedge aclk)
  begin
    if (scan_rst)
      bus_off <= 1'b0;
    else if (mode == 3'h3)
      bus_off <= 1'b1;
  end
endmodule

// file: verification/testbench.sv
// self-checking bench for fnc_node: register bus, lamps, link tick, irq
// assumes the node's assertions live in the design and ce stays high
`timescale 1ns/1ns
`include "fnc_regs.svh"

module testbench;
  import fnc_pkg::*;
  localparam logic [31:0] A_CFG = 32'h0000_0000;
  localparam logic [31:0] A_ST  = 32'h0000_0004;
  localparam logic [31:0] A_MSK = 32'h0000_0008;
  logic        aclk, aresetn, awvalid, wvalid, bvalid, bready, arvalid, rvalid, rready;
  logic        awready, wready, arready, tick, irq, mg, mr, ng, nr, scan_rst;
  logic [31:0] awaddr, wdata, araddr, rdata, d, error_cnt, num_checks;
  logic [1:0]  bresp, rresp, r, link_rate;
  logic [5:0]  brd;
  logic [2:0]  mode;
  logic        np, na, npl, nle, nto;
  int          cyc;

  fnc_node #(.FLASH_HALF_CYC(8)) i_dut (
    .aclk(aclk), .aresetn(aresetn), .ce(1'b1),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .board_present(brd[0]), .board_power(brd[1]), .board_fault(brd[2]),
    .board_unrecov(brd[3]), .board_recov(brd[4]), .board_selftest(brd[5]),
    .net_power(np), .net_attached(na), .net_polled(npl), .net_link_err(nle),
    .net_timeout(nto), .link_rate(link_rate), .link_bit_tick(tick),
    .module_health_lamp_green(mg), .module_health_lamp_red(mr),
    .network_health_lamp_green(ng), .network_health_lamp_red(nr), .irq(irq));

  fnc_scanner_model i_scan (
    .aclk(aclk), .mode(mode), .scan_rst(scan_rst), .net_power(np), .net_attached(na),
    .net_polled(npl), .net_link_err(nle), .net_timeout(nto));

  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic wrap_up;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks != 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      wrap_up();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [31:0] cfg(input logic [7:0] n, input logic [1:0] rt, f, o,
                                      input logic s);
    cfg = (32'(n) << `FNC_CFG_NODE_LSB) | (32'(rt) << `FNC_CFG_RATE_LSB)
        | (32'(f) << `FNC_CFG_FMT_LSB) | (32'(o) << `FNC_CFG_ORDER_LSB)
        | (32'(s) << `FNC_CFG_SLOTS_BIT);
  endfunction

  task automatic axi_wr(input logic [31:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic ta, tw, da, dw;
    da = 1'b0;
    dw = 1'b0;
    @(posedge aclk);
    awaddr <= a; awvalid <= 1'b1; wdata <= v; wvalid <= 1'b1; bready <= 1'b1;
    while (!(da && dw))
    begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      @(posedge aclk);
      if (ta) begin awvalid <= 1'b0; da = 1'b1; end
      if (tw) begin wvalid <= 1'b0; dw = 1'b1; end
    end
    do @(negedge aclk); while (!bvalid);
    rs = bresp;
    @(posedge aclk);
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [31:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do @(negedge aclk); while (!arready);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (!rvalid);
    v = rdata;
    rs = rresp;
    @(posedge aclk);
    rready <= 1'b0;
  endtask

  task automatic set_pins(input logic [5:0] b, input logic [2:0] m);
    @(posedge aclk);
    brd <= b;
    mode <= m;
    repeat (6) @(posedge aclk);
  endtask

  // lit cycles over one full flash period of 16
  task automatic lamps(output logic [31:0] c[4]);
    c = '{default: 32'h0};
    repeat (16)
    begin
      @(negedge aclk);
      c[0] += {31'h0, mg}; c[1] += {31'h0, mr}; c[2] += {31'h0, ng}; c[3] += {31'h0, nr};
    end
  endtask

  task automatic t_presence;
    axi_rd(A_CFG, d, r); chk(d, 32'h0);
    axi_wr(A_CFG, cfg(8'h05, 2'h1, 2'h0, 2'h0, 1'b1), r); chk({30'h0, r}, 32'h0);
    set_pins(6'b000011, 3'h0);
    axi_rd(A_CFG, d, r); chk(d, cfg(8'h3F, 2'h0, `FNC_FMT_INT, 2'h2, 1'b0));
    axi_rd(A_ST, d, r); chk(d, 32'h1);
  endtask

  task automatic t_node;
    axi_wr(A_CFG, cfg(8'h40, 2'h0, 2'h1, 2'h2, 1'b0), r); chk({30'h0, r}, 32'h0);
    axi_rd(A_CFG, d, r); chk({24'h0, d[7:0]}, 32'h3F);
    axi_rd(A_ST, d, r); chk(d, 32'h2);
    axi_wr(A_CFG, cfg(8'h00, 2'h0, 2'h1, 2'h2, 1'b0), r);
    axi_rd(A_CFG, d, r); chk({24'h0, d[7:0]}, 32'h0);
  endtask

  task automatic t_rate;
    int per[3] = '{`FNC_CLK_HZ / `FNC_BPS_125K, `FNC_CLK_HZ / `FNC_BPS_250K,
                   `FNC_CLK_HZ / `FNC_BPS_500K};
    int n;
    for (int k = 0; k < 3; k++)
    begin
      axi_wr(A_CFG, cfg(8'h00, 2'(k), 2'h1, 2'h2, 1'b0), r);
      do @(negedge aclk); while (tick !== 1'b1);
      n = 0;
      do begin @(negedge aclk); n++; end while (tick !== 1'b1);
      chk(32'(n), 32'(per[k]));
      chk({30'h0, link_rate}, 32'(k));
    end
    axi_wr(A_CFG, cfg(8'h00, 2'h3, 2'h1, 2'h2, 1'b0), r);
    axi_rd(A_ST, d, r); chk(d, 32'h2);
    chk({30'h0, link_rate}, 32'h2);
  endtask

  task automatic t_fmt;
    for (int o = 0; o < 4; o++)
      for (int f = 0; f < 3; f++)
      begin
        axi_wr(A_CFG, cfg(8'h01, 2'h0, 2'(f), 2'(o), 1'b1), r);
        axi_rd(A_CFG, d, r); chk(d, cfg(8'h01, 2'h0, 2'(f), 2'(o), f != 2));
      end
  endtask

  task automatic t_lamps;
    logic [5:0]  mp[6] = '{6'b000001, 6'b000011, 6'b000111, 6'b001011, 6'b010011, 6'b100011};
    logic [31:0] c[4], eg[6] = '{0, 16, 8, 0, 0, 8}, er[6] = '{0, 0, 0, 16, 8, 8};
    logic [31:0] fg[5] = '{0, 8, 16, 0, 0}, fr[5] = '{0, 0, 0, 16, 8};
    for (int k = 0; k < 6; k++)
    begin
      set_pins(mp[k], 3'h2);
      lamps(c); chk(c[0], eg[k]); chk(c[1], er[k]);
    end
    for (int k = 0; k < 5; k++)
    begin
      // scanner reset with the new mode already set, so the cable fault cannot re-latch
      if (k == 4)
      begin
        @(posedge aclk);
        scan_rst <= 1'b1;
        mode <= 3'h4;
        @(posedge aclk);
        scan_rst <= 1'b0;
      end
      set_pins(6'b000011, 3'(k));
      lamps(c); chk(c[2], fg[k]); chk(c[3], fr[k]);
    end
  endtask

  task automatic t_irq;
    set_pins(6'b000011, 3'h2);
    axi_wr(A_MSK, 32'h4, r);
    axi_rd(A_ST, d, r);
    set_pins(6'b000011, 3'h3);
    chk({31'h0, irq}, 32'h1);
    axi_rd(A_ST, d, r); chk(d, 32'h4);
    repeat (2) @(negedge aclk);
    chk({31'h0, irq}, 32'h0);
    axi_wr(A_MSK, 32'h0, r);
    // clear bus-off through a quiet polled spell so the timeout is a fresh rise
    @(posedge aclk); scan_rst <= 1'b1; mode <= 3'h2; @(posedge aclk); scan_rst <= 1'b0;
    set_pins(6'b000011, 3'h4);
    @(negedge aclk);
    chk({31'h0, irq}, 32'h0);
    axi_rd(A_ST, d, r); chk(d, 32'h4);
    axi_rd(32'h0000_000C, d, r); chk({18'h0, d[13:0]}, 32'h0000_14C3);
    axi_wr(32'h0000_0010, 32'h1, r); chk({30'h0, r}, 32'h2);
    axi_rd(32'h0000_0010, d, r); chk({d[29:0], r}, 32'h2);
  endtask

  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    scan_rst = 1'b1;
    {awaddr, wdata, araddr, error_cnt, num_checks} = '0;
    brd = 6'b000010;
    mode = 3'h0;
    cyc = 0;
    aresetn = 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    scan_rst <= 1'b0;
    @(negedge aclk);
    chk({29'h0, link_rate, irq}, 32'h0);
    t_presence();
    t_node();
    t_rate();
    t_fmt();
    t_lamps();
    t_irq();
    wrap_up();
  end
endmodule
